// [dcc_ctrl.sv]
// Behaviour
// [RULE_01] four packets at 30,32,34,36: count, address
// [RULE_02] multi-cycle: in three cycles, out four
// [RULE_03] software preloads negated count, address minus one
// [RULE_04] first cycle: count read, plus one, rewritten
// [RULE_05] count carry pulses overflow, stops device, interrupts; in increment mode the code gives no overflow pulse on the carry
// [RULE_06] second cycle: code plus one, address incremented
// [RULE_07] data moves at current address, adder inhibited
// [RULE_08] repeat until count zero, then completion interrupt
// [RULE_09] enabled device requests when buffer holds data
// [RULE_10] grant only when controller is idle
// [RULE_11] device drives packet code, stored unmodified
// [RULE_12] every memory access requests and awaits grant
// [RULE_13] output inserts one settling cycle before strobe
// [RULE_14] controller memory requests hold off the processor
// [RULE_15] single-cycle: one word per 1 us cycle
// [RULE_16] single-cycle device keeps own address and count
// [RULE_17] device drives address and data after grant
// [RULE_18] single-cycle writes bus data at device address
// [RULE_19] device counts itself, disables and interrupts on carry
// [RULE_20] single-cycle block at most 32768 words
// [RULE_21] increment memory: count step only, 500 kHz max
// [RULE_22] add-to-memory: sum rewritten and sent, four cycles
// [RULE_23] write half follows read, word modified between
// [RULE_24] adder carry on count increment ends block
`timescale 1ns/1ps
`include "dcc_map.svh"

module dcc_ctrl import dcc_pkg::*; #(
   parameter int CYC_CLKS = `DCC_CYC_CLKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // common i/o bus
   dcc_if.ctl io,
   // memory multiplexer port
   output logic mem_req,
   output logic [`DCC_WORD_W-1:0] mem_addr,
   input wire logic mem_ack,
   input wire logic [`DCC_WORD_W-1:0] mem_rdata,
   output logic mem_wr,
   output logic [`DCC_WORD_W-1:0] mem_wdata,
   output logic cpu_hold,
   // status
   output logic busy,
   output logic blk_irq
);

   localparam int W = `DCC_WORD_W;
   localparam int CW = $clog2(CYC_CLKS);

   dcc_state_t state;
   dcc_mode_t mode;
   logic [CW-1:0] div_cnt;
   logic cyc_en;
   logic [W-1:0] dsr;
   logic [W-1:0] cur_addr;
   logic [W-1:0] din;
   logic mem_done;

   // processor cycle divider
   wire div_wrap = (div_cnt == CW'(CYC_CLKS - 1));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt <= '0;
         cyc_en <= 1'b0;
      end else begin
         div_cnt <= div_wrap ? '0 : div_cnt + 1'b1;
         cyc_en <= div_wrap;
      end
   end

   // decoding of the current step
   wire needs_mem = (state == S_WC) || (state == S_CA) || (state == S_DATA) || (state == S_SC);
   wire mode_out = (mode == MODE_MC_OUT) || (mode == MODE_ADD);
   wire is_add_data = (state == S_DATA) && (mode == MODE_ADD);
   wire is_count = (state == S_WC) || (state == S_CA);
   wire plain_write = ((state == S_DATA) && (mode == MODE_MC_IN)) || (state == S_SC);

   // i/o adder: plus one on count steps, device word on add, else inhibited
   wire [W-1:0] add_b = is_add_data ? din :
                        is_count ? W'(1) : '0;                         // [RULE_07] [RULE_22]
   wire [W:0] sum = {1'b0, mem_rdata} + {1'b0, add_b};
   wire carry = sum[W];                                                 // [RULE_24]
   wire [W-1:0] code_plus1 = dsr + W'(1);                               // [RULE_06] [RULE_01]

   // packet code, then code plus one, then the current address
   wire [W-1:0] step_addr = (state == S_WC) ? dsr :                     // [RULE_04]
                            (state == S_CA) ? code_plus1 :              // [RULE_06]
                            (state == S_DATA) ? cur_addr : dsr;         // [RULE_07] [RULE_18]
   // modified word goes back after the read half
   wire [W-1:0] step_wdata = plain_write ? din : sum[W-1:0];            // [RULE_23]

   // a step ends on the first tick after its memory answer
   wire adv = cyc_en && ((state == S_SETTLE) || (needs_mem && mem_done));

   dcc_state_t next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE: next_state = io.ch_req ? S_GNT : S_IDLE;               // [RULE_10]
         S_GNT: next_state = S_CAPT;
         S_CAPT: next_state = (mode == MODE_SC_IN) ? S_SC : S_WC;
         S_WC: next_state = (mode == MODE_INCR) ? S_SETTLE : S_CA;      // [RULE_21]
         S_CA: next_state = mode_out ? S_SETTLE : S_DATA;               // [RULE_13] [RULE_02]
         S_SETTLE: next_state = (mode == MODE_INCR) ? S_IDLE : S_DATA;  // [RULE_21]
         S_DATA: next_state = S_IDLE;
         S_SC: next_state = S_IDLE;                                     // [RULE_15]
      endcase
   end

   // grant and capture move on any clock, later steps only on ticks
   wire take = (state == S_IDLE) || (state == S_GNT) || (state == S_CAPT) || adv;

   // sequencing
   // grant does not wait for a tick, so the first step may be short
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= S_IDLE;
         mode <= MODE_MC_IN;
         io.ch_gnt <= 1'b0;
         io.xfer_end <= 1'b0;
         busy <= 1'b0;
      end else begin
         io.ch_gnt <= (state == S_IDLE) && io.ch_req;                   // [RULE_10]
         io.xfer_end <= take && (state != S_IDLE) && (next_state == S_IDLE);
         if (take) begin
            state <= next_state;
         end
         if ((state == S_IDLE) && io.ch_req) begin
            mode <= io.mode;
            busy <= 1'b1;
         end else if (take && (next_state == S_IDLE)) begin
            busy <= 1'b0;
         end
      end
   end

   // capture of code or address and data from the bus
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dsr <= '0;
         din <= '0;
      end else if (state == S_CAPT) begin
         dsr <= io.bus_addr;                                            // [RULE_11] [RULE_18]
         din <= io.bus_data_dev;                                        // [RULE_17]
      end
   end

   // memory request, read then modified write
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_req <= 1'b0;
         mem_addr <= '0;
         mem_wr <= 1'b0;
         mem_wdata <= '0;
         mem_done <= 1'b0;
         cpu_hold <= 1'b0;
      end else begin
         mem_wr <= 1'b0;
         // processor waits until the read half of this step is done
         cpu_hold <= needs_mem && !mem_done && !(mem_req && mem_ack);   // [RULE_14]
         if (adv) begin
            mem_done <= 1'b0;
         end else if (mem_req && mem_ack) begin
            mem_req <= 1'b0;
            mem_wr <= 1'b1;
            mem_wdata <= step_wdata;
            mem_done <= 1'b1;
         end else if (needs_mem && !mem_req && !mem_done) begin
            mem_req <= 1'b1;                                            // [RULE_12]
            mem_addr <= step_addr;
         end
      end
   end

   // results of each memory step
   // overflow only from the count step, never from the data add
   wire acked = mem_req && mem_ack;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_addr <= '0;
         io.bus_data_ctl <= '0;
         io.data_stb <= 1'b0;
         io.ovf_pulse <= 1'b0;
         blk_irq <= 1'b0;
      end else begin
         io.data_stb <= 1'b0;
         io.ovf_pulse <= 1'b0;
         blk_irq <= 1'b0;
         if (acked && (state == S_CA)) begin
            cur_addr <= sum[W-1:0];                                     // [RULE_06]
         end
         if (acked && (state == S_WC) && carry && (mode != MODE_INCR)) begin
            io.ovf_pulse <= 1'b1;                                       // [RULE_05] [RULE_24]
            blk_irq <= 1'b1;                                            // [RULE_08]
         end
         if (acked && (state == S_DATA) && mode_out) begin
            io.bus_data_ctl <= step_wdata;                              // [RULE_22]
            io.data_stb <= 1'b1;                                        // [RULE_13]
         end
      end
   end

endmodule // dcc_ctrl

// [dcc_map.svh]
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// word and single-cycle count widths
`define DCC_WORD_W 18
`define DCC_SC_CNT_W 15

// fixed packet codes, two words each: count then current address
`define DCC_PKT_CH0 18'h00018
`define DCC_PKT_CH1 18'h0001A
`define DCC_PKT_CH2 18'h0001C
`define DCC_PKT_CH3 18'h0001E

// timing
`define DCC_CLK_NS 5
`define DCC_CYC_NS 1000
`define DCC_CYC_CLKS (`DCC_CYC_NS / `DCC_CLK_NS)

// single-cycle block limit
`define DCC_SC_MAX_WORDS 32768

// device-side data buffer
`define DCC_FIFO_DEPTH 8

`endif

// [dcc_pkg.sv]
package dcc_pkg;

   typedef enum logic [2:0] {
      MODE_MC_IN,
      MODE_MC_OUT,
      MODE_SC_IN,
      MODE_INCR,
      MODE_ADD
   } dcc_mode_t;

   typedef enum logic [2:0] {
      S_IDLE,
      S_GNT,
      S_CAPT,
      S_WC,
      S_CA,
      S_SETTLE,
      S_DATA,
      S_SC
   } dcc_state_t;

endpackage

// [dcc_if.sv]
`timescale 1ns/1ps
`include "dcc_map.svh"

interface dcc_if;
   import dcc_pkg::*;

   logic ch_req;
   dcc_mode_t mode;
   logic ch_gnt;
   logic [`DCC_WORD_W-1:0] bus_addr;
   logic [`DCC_WORD_W-1:0] bus_data_dev;
   logic [`DCC_WORD_W-1:0] bus_data_ctl;
   logic data_stb;
   logic ovf_pulse;
   logic xfer_end;

   modport ctl (
      input ch_req,
      input mode,
      input bus_addr,
      input bus_data_dev,
      output ch_gnt,
      output bus_data_ctl,
      output data_stb,
      output ovf_pulse,
      output xfer_end
   );

   modport dev (
      output ch_req,
      output mode,
      output bus_addr,
      output bus_data_dev,
      input ch_gnt,
      input bus_data_ctl,
      input data_stb,
      input ovf_pulse,
      input xfer_end
   );

endinterface // dcc_if

// [dcc_dev.sv]
`timescale 1ns/1ps
`include "dcc_map.svh"

module dcc_fifo #(
   parameter int W = `DCC_WORD_W,
   parameter int DEPTH = `DCC_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int NW = $clog2(DEPTH + 1);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [NW-1:0] count;

   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (count != NW'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + NW'(push) - NW'(pop);
      end
   end
endmodule // dcc_fifo

module dcc_dev import dcc_pkg::*; #(
   parameter logic [`DCC_WORD_W-1:0] PKT_CODE = `DCC_PKT_CH0,
   parameter int DEPTH = `DCC_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // common i/o bus
   dcc_if.dev io,
   // io_transfer_instruction pulses from the processor
   input wire logic it_load_addr,
   input wire logic it_load_count,
   input wire logic it_start,
   input wire logic it_stop,
   input wire dcc_mode_t it_mode,
   input wire logic [`DCC_WORD_W-1:0] it_data,
   // device data in
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [`DCC_WORD_W-1:0] in_data,
   // device data out
   output logic out_valid,
   output logic [`DCC_WORD_W-1:0] out_data,
   // status
   output logic enabled,
   output logic done_irq
);
   localparam int W = `DCC_WORD_W;
   localparam int CNTW = `DCC_SC_CNT_W;

   logic f_valid;
   logic [W-1:0] f_data;
   logic pending;
   logic [W-1:0] cur_addr;
   logic [CNTW-1:0] wcount;

   wire needs_data = (io.mode == MODE_MC_IN) || (io.mode == MODE_SC_IN) ||
                     (io.mode == MODE_ADD);
   wire is_sc = (io.mode == MODE_SC_IN);
   wire pop = io.ch_gnt && needs_data;
   wire [CNTW:0] wc_inc = {1'b0, wcount} + (CNTW+1)'(1);
   wire sc_last = is_sc && io.xfer_end && wc_inc[CNTW];                 // [RULE_20]
   wire want = enabled && !pending && !io.ch_req && (!needs_data || f_valid);

   dcc_fifo #(.W(W), .DEPTH(DEPTH)) dcc_fifo_i (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(in_valid),
      .in_ready(in_ready),
      .in_data(in_data),
      .out_valid(f_valid),
      .out_ready(pop),
      .out_data(f_data)
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         enabled <= 1'b0;
         io.mode <= MODE_MC_IN;
         io.ch_req <= 1'b0;
         io.bus_addr <= '0;
         io.bus_data_dev <= '0;
         pending <= 1'b0;
         cur_addr <= '0;
         wcount <= '0;
         done_irq <= 1'b0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         done_irq <= 1'b0;
         out_valid <= 1'b0;
         if (it_load_addr) begin
            cur_addr <= it_data;                                        // [RULE_16]
         end
         if (it_load_count) begin
            wcount <= it_data[CNTW-1:0];                                // [RULE_16]
         end
         // mode held while a granted word is still in flight
         if (it_mode != io.mode && !enabled && !pending) begin
            io.mode <= it_mode;
         end
         if (io.ch_gnt) begin
            io.ch_req <= 1'b0;
            pending <= 1'b1;
            io.bus_addr <= is_sc ? cur_addr : PKT_CODE;                 // [RULE_11] [RULE_17]
            io.bus_data_dev <= f_data;                                  // [RULE_17]
         end else if (want) begin
            io.ch_req <= 1'b1;                                          // [RULE_09]
         end
         if (io.xfer_end) begin
            pending <= 1'b0;
            if (is_sc) begin
               cur_addr <= cur_addr + W'(1);                            // [RULE_19]
               wcount <= wc_inc[CNTW-1:0];                              // [RULE_19]
            end
         end
         if (io.data_stb) begin
            out_data <= io.bus_data_ctl;
            out_valid <= 1'b1;
         end
         if (io.ovf_pulse || sc_last) begin
            enabled <= 1'b0;                                            // [RULE_05] [RULE_19]
            done_irq <= 1'b1;
         end else if (it_stop || (io.xfer_end && io.mode == MODE_INCR)) begin
            enabled <= 1'b0;
         end else if (it_start) begin
            enabled <= 1'b1;
         end
      end
   end

endmodule // dcc_dev

// [dcc_properties.sv]
`timescale 1ns/1ps
`include "dcc_map.svh"

module dcc_properties import dcc_pkg::*; #(
   parameter logic [`DCC_WORD_W-1:0] PKT = `DCC_PKT_CH0
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // device to controller
   input wire logic ch_req,
   input wire dcc_mode_t mode,
   input wire logic [`DCC_WORD_W-1:0] bus_addr,
   input wire logic [`DCC_WORD_W-1:0] bus_data_dev,
   // controller to device
   input wire logic ch_gnt,
   input wire logic [`DCC_WORD_W-1:0] bus_data_ctl,
   input wire logic data_stb,
   input wire logic ovf_pulse,
   input wire logic xfer_end
);
   localparam int MAX_XFER = 400;
   logic act;
   wire logic next_act = ch_gnt | (act & ~xfer_end);

   // grant taken until the controller ends it
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         act <= 1'b0;
      end else begin
         act <= next_act;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);

   gnt_pulse_a: assert property (ch_gnt |=> !ch_gnt)
      else $error("grant held too long");
   gnt_idle_a: assert property (ch_gnt |-> !act && $past(ch_req))
      else $error("grant while busy or unrequested");
   end_in_xfer_a: assert property (xfer_end |-> act)
      else $error("end without grant");
   xfer_bound_a: assert property (ch_gnt |-> ##[2:MAX_XFER] xfer_end)
      else $error("transfer never ended");
   req_drop_a: assert property (ch_gnt |=> !ch_req)
      else $error("request held after grant");
   addr_hold_a: assert property (act && $past(act, 2) |-> $stable(bus_addr))
      else $error("bus address moved in transfer");
   pkt_code_a: assert property (act && $past(act, 2) && mode != MODE_SC_IN |-> bus_addr == PKT)
      else $error("wrong packet code");
   sc_data_a: assert property (act && $past(act, 2) && mode == MODE_SC_IN |-> $stable(bus_data_dev))
      else $error("single-cycle data moved");
   stb_mode_a: assert property (data_stb |-> act && (mode == MODE_MC_OUT || mode == MODE_ADD))
      else $error("strobe in wrong mode");
   ovf_mode_a: assert property (ovf_pulse |-> act && mode != MODE_SC_IN && mode != MODE_INCR)
      else $error("overflow in wrong mode");

   cover property (ch_gnt && mode == MODE_SC_IN);
   cover property (data_stb && mode == MODE_ADD);
   cover property (ovf_pulse && mode == MODE_MC_IN);
   cover property (xfer_end && mode == MODE_INCR);
endmodule // dcc_properties

// [test_data_channel_controller.sv]
`timescale 1ns/1ps
`include "dcc_map.svh"

module test_data_channel_controller import dcc_pkg::*; ;
   localparam int CYC = 16;
   localparam int W = `DCC_WORD_W;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] it_sel = 4'h0;
   dcc_mode_t it_mode = MODE_MC_IN;
   logic [W-1:0] it_data = 18'h00000;
   logic in_valid = 1'b0;
   logic [W-1:0] in_data = 18'h00000;
   logic mem_ack = 1'b0;
   logic [W-1:0] mem_rdata = 18'h00000;
   logic [W-1:0] mem [0:255];
   logic [W-1:0] last_out = 18'h00000;
   wire logic mem_req, mem_wr, cpu_hold, busy, blk_irq, in_ready, out_valid, enabled, done_irq;
   wire logic [W-1:0] mem_addr, mem_wdata, out_data;
   int err_total = 0;
   int n_checks = 0;
   int lat = 0;
   int wcnt = 0;
   int n_blk = 0;
   int n_done = 0;

   always #2.5 clk = ~clk;

   dcc_if dcc_if_i ();
   dcc_ctrl #(.CYC_CLKS(CYC)) dcc_ctrl_i (.clk(clk), .arst_n(arst_n), .io(dcc_if_i.ctl),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .cpu_hold(cpu_hold), .busy(busy),
      .blk_irq(blk_irq));
   dcc_dev #(.PKT_CODE(`DCC_PKT_CH0), .DEPTH(`DCC_FIFO_DEPTH)) dcc_dev_i (.clk(clk),
      .arst_n(arst_n), .io(dcc_if_i.dev), .it_load_addr(it_sel[3]), .it_load_count(it_sel[2]),
      .it_start(it_sel[1]), .it_stop(it_sel[0]), .it_mode(it_mode), .it_data(it_data),
      .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid),
      .out_data(out_data), .enabled(enabled), .done_irq(done_irq));
   dcc_properties #(.PKT(`DCC_PKT_CH0)) dcc_properties_i (.clk(clk), .arst_n(arst_n),
      .ch_req(dcc_if_i.ch_req), .mode(dcc_if_i.mode), .bus_addr(dcc_if_i.bus_addr),
      .bus_data_dev(dcc_if_i.bus_data_dev), .ch_gnt(dcc_if_i.ch_gnt),
      .bus_data_ctl(dcc_if_i.bus_data_ctl), .data_stb(dcc_if_i.data_stb),
      .ovf_pulse(dcc_if_i.ovf_pulse), .xfer_end(dcc_if_i.xfer_end));

   task chk(input logic [W-1:0] got, input logic [W-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // memory answers after lat cycles; read data is scrambled outside the ack
   always @(negedge clk) begin
      if (mem_req === 1'b1 && !mem_ack) begin
         if (wcnt >= lat) begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[7:0]];
            wcnt <= 0;
            chk({17'h00000, cpu_hold}, 18'h00001);
            chk({17'h00000, busy}, 18'h00001);
         end else begin
            wcnt <= wcnt + 1;
         end
      end else begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end
   end

   always @(posedge clk) begin
      if (mem_wr === 1'b1) mem[mem_addr[7:0]] <= mem_wdata;
      if (blk_irq === 1'b1) n_blk <= n_blk + 1;
      if (done_irq === 1'b1) n_done <= n_done + 1;
      if (out_valid === 1'b1) last_out <= out_data;
   end

   task it_op(input logic [3:0] sel, input logic [W-1:0] d);
      @(negedge clk);
      it_sel = sel;
      it_data = d;
      @(negedge clk);
      it_sel = 4'h0;
   endtask

   task push(input logic [W-1:0] d);
      int n;
      @(negedge clk);
      in_valid = 1'b1;
      in_data = d;
      for (n = 0; n < 100 && in_ready !== 1'b1; n++) @(negedge clk);
      if (n == 100) chk(18'h00001, 18'h00000);
      if (n == 100) tally_and_finish();
      @(negedge clk);
      in_valid = 1'b0;
   endtask

   task run(input dcc_mode_t m);
      int n;
      @(negedge clk);
      it_mode = m;
      it_op(4'h2, 18'h00000);
      chk({17'h00000, enabled}, 18'h00001);
      for (n = 0; n < 3000 && enabled !== 1'b0; n++) @(negedge clk);
      if (n == 3000) chk(18'h00001, 18'h00000);
      if (n == 3000) tally_and_finish();
      repeat (6 * CYC) @(negedge clk);
      chk({17'h00000, busy}, 18'h00000);
      chk({17'h00000, cpu_hold}, 18'h00000);
   endtask

   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 18'h00000;
      repeat (20) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      // two-word block into memory
      mem[8'h18] = 18'h3FFFE;
      mem[8'h19] = 18'h0003F;
      push(18'h12345);
      push(18'h2A5A5);
      run(MODE_MC_IN);
      chk(mem[8'h18], 18'h00000);
      chk(mem[8'h19], 18'h00041);
      chk(mem[8'h40], 18'h12345);
      chk(mem[8'h41], 18'h2A5A5);
      chk(n_blk[17:0], 18'h00001);
      // buffer filled until it refuses, drained by a slow-memory block
      lat = 2;
      for (int i = 0; i < 8; i++) push(18'h20000 + i[17:0]);
      @(negedge clk);
      chk({17'h00000, in_ready}, 18'h00000);
      n_done = 0;
      it_op(4'h8, 18'h00050);
      it_op(4'h4, 18'h3FFF8);
      run(MODE_SC_IN);
      for (int i = 0; i < 8; i++) chk(mem[8'h50 + i[7:0]], 18'h20000 + i[17:0]);
      chk(n_done[17:0], 18'h00001);
      lat = 0;
      // one-shot increment of the packet word
      mem[8'h18] = 18'h00005;
      run(MODE_INCR);
      chk(mem[8'h18], 18'h00006);
      chk(mem[8'h19], 18'h00041);
      // add a device word into memory
      mem[8'h18] = 18'h3FFFF;
      mem[8'h19] = 18'h0005F;
      mem[8'h60] = 18'h00100;
      push(18'h00023);
      run(MODE_ADD);
      chk(mem[8'h60], 18'h00123);
      chk(last_out, 18'h00123);
      chk(mem[8'h18], 18'h00000);
      // one word out of memory
      mem[8'h18] = 18'h3FFFF;
      mem[8'h19] = 18'h0006F;
      mem[8'h70] = 18'h2ABCD;
      run(MODE_MC_OUT);
      chk(last_out, 18'h2ABCD);
      chk(mem[8'h70], 18'h2ABCD);
      chk(mem[8'h19], 18'h00070);
      // block ends: first block, add and output each once
      chk(n_blk[17:0], 18'h00003);
      // device completions: single-cycle, add and output
      chk(n_done[17:0], 18'h00003);
      tally_and_finish();
   end
endmodule // test_data_channel_controller
